// ---- design/lfdr_ch_flags.sv ----
`timescale 1ns/1ps
// per-channel fault flag capture for one scan line
module lfdr_ch_flags
  import lfdr_pkg::*;
#(
  parameter int NCH = 48
) (
  input  wire logic           clk,
  input  wire logic           rst,
  input  wire logic [NCH-1:0] drive_on,
  input  wire logic [NCH-1:0] open_cmp,
  input  wire logic [NCH-1:0] short_cmp,
  input  wire logic           seg_start,
  output logic      [NCH-1:0] open_flags,
  output logic      [NCH-1:0] short_flags
);
  logic [NCH-1:0] open_r, open_nxt;
  logic [NCH-1:0] short_r, short_nxt;

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      // comparator only trusted while the channel is on
      always_comb begin
        open_nxt[g]  = seg_start ? 1'b0 : open_r[g];
        short_nxt[g] = seg_start ? 1'b0 : short_r[g];
        if (drive_on[g] && open_cmp[g]) begin
          open_nxt[g] = 1'b1;
        end
        if (drive_on[g] && short_cmp[g]) begin
          short_nxt[g] = 1'b1;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (rst) begin
      open_r  <= '0;
      short_r <= '0;
    end else begin
      open_r  <= open_nxt;
      short_r <= short_nxt;
    end
  end

  assign open_flags  = open_nxt;
  assign short_flags = short_nxt;
endmodule : lfdr_ch_flags

// ---- design/lfdr_consts.svh ----
`ifndef LFDR_CONSTS_SVH
`define LFDR_CONSTS_SVH
// register byte offsets
`define LFDR_OFF_CTRL        12'h000
`define LFDR_OFF_THRESH      12'h004
`define LFDR_OFF_STATUS      12'h008
`define LFDR_OFF_LINE_WARN   12'h00c
`define LFDR_OFF_OPEN_LO     12'h010
`define LFDR_OFF_OPEN_HI     12'h014
`define LFDR_OFF_SHORT_LO    12'h018
`define LFDR_OFF_SHORT_HI    12'h01c
`define LFDR_OFF_RM_LINES    12'h020
// control field positions
`define LFDR_CTRL_RB_EN_BIT  0
`define LFDR_CTRL_RM_EN_BIT  1
// reset values
`define LFDR_CTRL_RST        32'h0000_0000
`define LFDR_THRESH_RST      24'h00_0000
// removal record slots
`define LFDR_RM_SLOTS        3
`endif

// ---- design/lfdr_pkg.sv ----
package lfdr_pkg;
  // per-colour comparator threshold codes
  typedef struct packed {
    logic [3:0] short_thresh_blue;
    logic [3:0] short_thresh_green;
    logic [3:0] short_thresh_red;
    logic [3:0] open_thresh_blue;
    logic [3:0] open_thresh_green;
    logic [3:0] open_thresh_red;
  } lfdr_thresh_s;

  // one removal record: line and faulty channels
  typedef struct packed {
    logic        valid;
    logic [3:0]  line;
    logic [47:0] chans;
  } lfdr_rm_rec_s;

  typedef enum logic [1:0] {
    LFDR_PROT_RUN   = 2'b00,
    LFDR_PROT_BLANK = 2'b01
  } lfdr_prot_e;
endpackage : lfdr_pkg

// ---- design/lfdr_top.sv ----
`timescale 1ns/1ps
// How it works
// - over-temperature blanks all outputs until cleared
// - reference short blanks all outputs until cleared
// - open flag set when voltage above threshold
// - open threshold per red, green, blue
// - open results used only while driven
// - open line recorded, vector latched per segment
// - short flag set when voltage below threshold
// - short threshold per red, green, blue
// - short results used only while driven
// - short line recorded, vector latched per segment
// - short vector red, green, blue bit bands
// - removal blanks open-faulty channel on recorded line
// - blanking kept until reset or disable
// - at most first three faulty lines removed
`include "lfdr_consts.svh"
module lfdr_top
  import lfdr_pkg::*;
#(
  parameter int NCH   = 48,
  parameter int LINEW = 4
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              over_temp_shutdown,
  input  wire logic              ref_short_protect,
  input  wire logic [LINEW-1:0]  scan_line,
  input  wire logic              seg_end,
  input  wire logic [NCH-1:0]    chan_request,
  input  wire logic [NCH-1:0]    open_cmp,
  input  wire logic [NCH-1:0]    short_cmp,
  output logic      [NCH-1:0]    channel_output,
  output logic      [23:0]       thresh_codes
);
  logic                ctrl_rb_r, ctrl_rb_nxt;
  logic                ctrl_rm_r, ctrl_rm_nxt;
  lfdr_thresh_s        thr_r, thr_nxt;
  logic [LINEW-1:0]    open_line_r, open_line_nxt;
  logic [LINEW-1:0]    short_line_r, short_line_nxt;
  logic                open_seen_r, open_seen_nxt;
  logic                short_seen_r, short_seen_nxt;
  logic [NCH-1:0]      open_vec_r, open_vec_nxt;
  logic [NCH-1:0]      short_vec_r, short_vec_nxt;
  lfdr_rm_rec_s [2:0]  rm_r, rm_nxt;
  logic [NCH-1:0]      out_r, out_nxt;
  logic [23:0]         thr_out_r;
  logic [31:0]         prdata_r, prdata_nxt;
  logic                pready_r, pready_nxt;
  logic                pslverr_r, pslverr_nxt;
  lfdr_prot_e          prot_r, prot_nxt;
  logic [NCH-1:0]      open_flags, short_flags;
  logic                seg_end_d_r;
  logic                bus_wr;
  logic                hit_line;
  logic [NCH-1:0]      rm_mask;
  logic [2:0]          slot_hit;
  logic [NCH-1:0]      slot_mask [2:0];

  // flags restart each segment after the previous end
  lfdr_ch_flags #(.NCH(NCH)) u_flags (
    .clk         (clk),
    .rst         (rst),
    .drive_on    (out_r),
    .open_cmp    (open_cmp),
    .short_cmp   (short_cmp),
    .seg_start   (seg_end_d_r),
    .open_flags  (open_flags),
    .short_flags (short_flags)
  );

  // writes land at the edge that completes the access, as the master sees it
  assign bus_wr = psel && penable && pwrite && pready_r;

  // protection blanking state
  always_comb begin
    prot_nxt = LFDR_PROT_RUN;
    if (over_temp_shutdown || ref_short_protect) begin
      prot_nxt = LFDR_PROT_BLANK;
    end
  end

  // protection state; no hysteresis here, since the detectors
  // upstream already hold their indication until the release level
  always_ff @(posedge clk) begin
    if (rst) begin
      prot_r <= LFDR_PROT_BLANK;
    end else begin
      prot_r <= prot_nxt;
    end
  end

  // register writes from the bus
  always_comb begin
    ctrl_rb_nxt = ctrl_rb_r;
    ctrl_rm_nxt = ctrl_rm_r;
    thr_nxt     = thr_r;
    if (bus_wr && paddr == `LFDR_OFF_CTRL) begin
      ctrl_rb_nxt = pwdata[`LFDR_CTRL_RB_EN_BIT];
      ctrl_rm_nxt = pwdata[`LFDR_CTRL_RM_EN_BIT];
    end
    if (bus_wr && paddr == `LFDR_OFF_THRESH) begin
      thr_nxt = pwdata[23:0];
    end
  end

  // control and thresholds; the port copy keeps thresh_codes a flop
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_rb_r <= 1'b0;
      ctrl_rm_r <= 1'b0;
      thr_r     <= `LFDR_THRESH_RST;
      thr_out_r <= `LFDR_THRESH_RST;
    end else begin
      ctrl_rb_r <= ctrl_rb_nxt;
      ctrl_rm_r <= ctrl_rm_nxt;
      thr_r     <= thr_nxt;
      thr_out_r <= thr_nxt;
    end
  end

  // line warnings and segment vectors
  always_comb begin
    open_line_nxt  = open_line_r;
    short_line_nxt = short_line_r;
    open_seen_nxt  = open_seen_r;
    short_seen_nxt = short_seen_r;
    open_vec_nxt   = open_vec_r;
    short_vec_nxt  = short_vec_r;
    if (|(open_cmp & out_r)) begin
      open_line_nxt = scan_line;
      open_seen_nxt = 1'b1;
    end
    if (|(short_cmp & out_r)) begin
      short_line_nxt = scan_line;
      short_seen_nxt = 1'b1;
    end
    if (seg_end) begin
      open_vec_nxt  = open_flags;
      short_vec_nxt = short_flags;
    end
  end

  // warning lines, seen bits and latched vectors
  always_ff @(posedge clk) begin
    if (rst) begin
      open_line_r  <= '0;
      short_line_r <= '0;
      open_seen_r  <= 1'b0;
      short_seen_r <= 1'b0;
      open_vec_r   <= '0;
      short_vec_r  <= '0;
    end else begin
      open_line_r  <= open_line_nxt;
      short_line_r <= short_line_nxt;
      open_seen_r  <= open_seen_nxt;
      short_seen_r <= short_seen_nxt;
      open_vec_r   <= open_vec_nxt;
      short_vec_r  <= short_vec_nxt;
    end
  end

  // open removal records; first three lines only
  always_comb begin
    logic placed;
    placed = 1'b0;
    rm_nxt = rm_r;
    if (!ctrl_rm_r) begin
      rm_nxt = '0;
    end else if (seg_end && |open_flags) begin
      for (int i = 0; i < `LFDR_RM_SLOTS; i++) begin
        if (rm_r[i].valid && rm_r[i].line == scan_line) begin
          rm_nxt[i].chans = rm_r[i].chans | open_flags;
          placed = 1'b1;
        end
      end
      for (int i = 0; i < `LFDR_RM_SLOTS; i++) begin
        if (!placed && !rm_r[i].valid) begin
          rm_nxt[i].valid = 1'b1;
          rm_nxt[i].line  = scan_line;
          rm_nxt[i].chans = open_flags;
          placed = 1'b1;
        end
      end
    end
  end

  // removal records; reset clears them as well as disable does
  // held until reset or removal disable
  always_ff @(posedge clk) begin
    if (rst) begin
      rm_r <= '0;
    end else begin
      rm_r <= rm_nxt;
    end
  end

  // per-slot line match; a slot masks only while removal is enabled
  // slot line match
  genvar s;
  generate
    for (s = 0; s < `LFDR_RM_SLOTS; s++) begin : g_slot
      assign slot_hit[s]  = ctrl_rm_r && rm_r[s].valid && (rm_r[s].line == scan_line);
      assign slot_mask[s] = slot_hit[s] ? rm_r[s].chans : '0;
    end
  endgenerate

  // channel outputs with blanking applied
  always_comb begin
    hit_line = |slot_hit;
    rm_mask  = '0;
    for (int i = 0; i < `LFDR_RM_SLOTS; i++) begin
      rm_mask = rm_mask | slot_mask[i];
    end
    out_nxt = chan_request & ~rm_mask;
    if (prot_nxt == LFDR_PROT_BLANK) begin
      out_nxt = '0;
    end
  end

  // channel outputs; one cycle behind request, line and protection
  always_ff @(posedge clk) begin
    if (rst) begin
      out_r <= '0;
    end else begin
      out_r <= out_nxt;
    end
  end

  // apb read and answer; one wait state
  always_comb begin
    pready_nxt  = psel && penable && !pready_r;
    pslverr_nxt = 1'b0;
    prdata_nxt  = '0;
    if (psel && penable && !pready_r) begin
      unique case (paddr)
        `LFDR_OFF_CTRL:      prdata_nxt = {30'h0, ctrl_rm_r, ctrl_rb_r};
        `LFDR_OFF_THRESH:    prdata_nxt = {8'h00, thr_r};
        `LFDR_OFF_STATUS:    prdata_nxt = {28'h0, hit_line, short_seen_r,
                                           open_seen_r, prot_r == LFDR_PROT_BLANK};
        `LFDR_OFF_LINE_WARN: prdata_nxt = ctrl_rb_r ?
                                          {16'h0, 4'h0, short_line_r, 4'h0, open_line_r}
                                          : 32'h0;
        `LFDR_OFF_OPEN_LO:   prdata_nxt = ctrl_rb_r ? open_vec_r[31:0] : 32'h0;
        `LFDR_OFF_OPEN_HI:   prdata_nxt = ctrl_rb_r ? {16'h0, open_vec_r[47:32]} : 32'h0;
        `LFDR_OFF_SHORT_LO:  prdata_nxt = ctrl_rb_r ? short_vec_r[31:0] : 32'h0;
        `LFDR_OFF_SHORT_HI:  prdata_nxt = ctrl_rb_r ? {16'h0, short_vec_r[47:32]} : 32'h0;
        `LFDR_OFF_RM_LINES:  prdata_nxt = {17'h0, rm_r[2].valid, rm_r[2].line,
                                           rm_r[1].valid, rm_r[1].line,
                                           rm_r[0].valid, rm_r[0].line};
        default:             pslverr_nxt = 1'b1;
      endcase
    end
  end

  // bus answer registers; the answer stands for exactly one cycle,
  // so a master that stretches the access sees a fresh pulse every second cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      prdata_r  <= '0;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      prdata_r  <= prdata_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // segment end delayed by one cycle restarts the flags, so the
  // latch at seg_end still sees the last cycle of the segment
  always_ff @(posedge clk) begin
    if (rst) begin
      seg_end_d_r <= 1'b0;
    end else begin
      seg_end_d_r <= seg_end;
    end
  end

  assign channel_output = out_r;
  assign thresh_codes   = thr_out_r;
  assign prdata         = prdata_r;
  assign pready         = pready_r;
  assign pslverr        = pslverr_r;
endmodule : lfdr_top

// ---- verif/lfdr_led_model.sv ----
`timescale 1ns/1ps
// led matrix stand-in: a fault reads true on a driven faulty channel, while undriven channels chatter
module lfdr_led_model #(
  parameter int NCH = 48
) (
  input  wire logic           clk,
  input  wire logic [NCH-1:0] channel_output,
  input  wire logic [NCH-1:0] open_bad,
  input  wire logic [NCH-1:0] short_bad,
  output logic      [NCH-1:0] open_cmp,
  output logic      [NCH-1:0] short_cmp
);
  logic [NCH-1:0] junk_r;
  // undriven pins float, so idle comparators chatter every cycle
  always_ff @(posedge clk) begin
    junk_r <= (junk_r === '1) ? '0 : '1;
  end
  assign open_cmp  = (channel_output & open_bad) | (~channel_output & junk_r);
  assign short_cmp = (channel_output & short_bad) | (~channel_output & junk_r);
endmodule : lfdr_led_model

// ---- verif/lfdr_sva.sv ----
`timescale 1ns/1ps
// port-level checks on blanking, outputs within request, threshold writes and bus answers
module lfdr_sva #(
  parameter int NCH   = 48,
  parameter int LINEW = 4
) (
  input wire logic            clk,
  input wire logic            rst,
  input wire logic            psel,
  input wire logic            penable,
  input wire logic            pwrite,
  input wire logic [31:0]     prdata,
  input wire logic            pready,
  input wire logic            pslverr,
  input wire logic            over_temp_shutdown,
  input wire logic            ref_short_protect,
  input wire logic [NCH-1:0]  chan_request,
  input wire logic [NCH-1:0]  channel_output,
  input wire logic [23:0]     thresh_codes
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // an access phase still waiting for its answer
  sequence acc_s;
    psel && penable && !pready;
  endsequence
  hot_blank_a: assert property (over_temp_shutdown |=> channel_output == '0)
    else $error("output driven while hot");
  ref_blank_a: assert property (ref_short_protect |=> channel_output == '0)
    else $error("output driven during ref short");
  out_subset_a: assert property (1'b1 |=> (channel_output & ~$past(chan_request)) == '0)
    else $error("unrequested channel driven");
  thr_write_a: assert property ($changed(thresh_codes) |-> $past(pready && pwrite))
    else $error("thresholds moved without write");
  ready_bound_a: assert property (acc_s |=> pready)
    else $error("no answer one cycle after access");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held over two cycles");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  err_data_a: assert property (pslverr |-> prdata == '0)
    else $error("refused read returned data");
endmodule : lfdr_sva

bind lfdr_top lfdr_sva #(.NCH(NCH), .LINEW(LINEW)) chk_u (.clk(clk), .rst(rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .over_temp_shutdown(over_temp_shutdown),
  .ref_short_protect(ref_short_protect), .chan_request(chan_request),
  .channel_output(channel_output), .thresh_codes(thresh_codes));

// ---- verif/tb_led_fault_detect_removal.sv ----
`timescale 1ns/1ps
module tb_led_fault_detect_removal;
  logic        clk, rst, psel, penable, pwrite, seg_end, hot, refs, pready, pslverr, rd_e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_v;
  logic [3:0]  line;
  logic [47:0] req, ocmp, scmp, obad, sbad, chout;
  logic [23:0] thr;
  int          n_errors, n_compared, cyc_n;
  // line warn, open lo/hi, short lo/hi after the detect segment
  localparam logic [31:0] RB_EXP [5] = '{32'h0202, 32'h8, 32'h0, 32'h0, 32'h20};

  lfdr_top dut_u (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .over_temp_shutdown(hot), .ref_short_protect(refs), .scan_line(line),
    .seg_end(seg_end), .chan_request(req), .open_cmp(ocmp), .short_cmp(scmp),
    .channel_output(chout), .thresh_codes(thr));
  lfdr_led_model led_u (.clk(clk), .channel_output(chout), .open_bad(obad),
    .short_bad(sbad), .open_cmp(ocmp), .short_cmp(scmp));

  always #5 clk = ~clk;
  // hang guard, far above the hundred-odd cycles the run needs
  always @(posedge clk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 5000) begin
      n_errors = n_errors + 1;
      close_out();
    end
  end

  task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // one apb transfer, waiting as long as the slave needs
  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd_v = prdata;
    rd_e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  // one segment on line l with the given faulty leds, closed by seg_end
  task automatic seg(input logic [3:0] l, input logic [47:0] ob, input logic [47:0] sb);
    @(posedge clk);
    line <= l;
    obad <= ob;
    sbad <= sb;
    repeat (3) @(posedge clk);
    seg_end <= 1'b1;
    @(posedge clk);
    seg_end <= 1'b0;
    obad <= '0;
    sbad <= '0;
  endtask : seg
  task automatic outp(input string nm, input logic [3:0] l, input logic [47:0] e);
    @(posedge clk);
    line <= l;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk(nm, e, chout);
  endtask : outp
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out

  initial begin
    {clk, psel, penable, pwrite, seg_end, hot, refs} = '0;
    rst = 1'b1;
    {paddr, pwdata, line, obad, sbad, cyc_n, n_errors, n_compared} = '0;
    req = '1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    // reset values, a refused address, then per-colour thresholds
    xfer(12'h000, 1'b0, '0);
    chk("ctrl", '0, 48'(rd_v));
    xfer(12'h040, 1'b0, '0);
    chk("unmapped err", 48'h1, 48'(rd_e));
    xfer(12'h004, 1'b1, 32'h0065_4321);
    @(negedge clk);
    chk("thresh port", 48'h65_4321, 48'(thr));
    $display("test registers done");
    xfer(12'h000, 1'b1, 32'h1);
    req <= 48'hffff_ffff_fbff;
    // channel 10 off, so its open fault must not count
    // a whole segment passes before readback
    seg(4'h2, 48'h0000_0000_0408, 48'h0020_0000_0000);
    for (int i = 0; i < 5; i++) begin
      xfer(12'h00c + 12'(4 * i), 1'b0, '0);
      chk("readback", 48'(RB_EXP[i]), 48'(rd_v));
    end
    xfer(12'h008, 1'b0, '0);
    chk("status", 48'h6, 48'(rd_v));
    xfer(12'h000, 1'b1, 32'h0);
    xfer(12'h010, 1'b0, '0);
    chk("gated read", '0, 48'(rd_v));
    $display("test detection done");
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      hot <= (i == 0);
      refs <= (i == 1);
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk("blanked", '0, chout);
      @(posedge clk);
      hot <= 1'b0;
      refs <= 1'b0;
      outp("restored", 4'h2, req);
    end
    $display("test protection done");
    // four faulty lines, only three kept
    xfer(12'h000, 1'b1, 32'h2);
    req <= '1;
    for (int i = 1; i < 5; i++) seg(4'(i), 48'h1 << i, '0);
    for (int i = 1; i < 5; i++) outp("removal", 4'(i), (i < 4) ? ~(48'h1 << i) : '1);
    xfer(12'h020, 1'b0, '0);
    chk("removal lines", 48'h4e51, 48'(rd_v));
    xfer(12'h000, 1'b1, 32'h0);
    outp("removal off", 4'h1, '1);
    xfer(12'h020, 1'b0, '0);
    chk("records cleared", '0, 48'(rd_v));
    $display("test removal done");
    close_out();
  end
endmodule : tb_led_fault_detect_removal
